//--- rtl/fcsr_pkg.sv
package fcsr_pkg;
    // word address width of the larger variant, 16-bit words
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned BIT_W = 4;
    localparam int unsigned WORD_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
    localparam logic [BIT_W-1:0] BIT_RESET = 4'h0;
    // page spans and device tops
    localparam logic [ADDR_W-1:0] PAGE_SPAN_4M = 19'h10000;
    localparam logic [ADDR_W-1:0] PAGE_TOP_4M = 19'h0FFFF;
    localparam logic [ADDR_W-1:0] PAGE_SPAN_8M = 19'h20000;
    localparam logic [ADDR_W-1:0] PAGE_TOP_8M = 19'h1FFFF;
    localparam logic [ADDR_W-1:0] DEV_TOP_4M = 19'h3FFFF;
    localparam logic [ADDR_W-1:0] DEV_TOP_8M = 19'h7FFFF;
    localparam int unsigned READY_DELAY = 16;
    // synchronised pins: seven controls, then page enable and page select
    localparam int unsigned SYNC_N = 10;
    // controls idle high, page inputs idle low
    localparam logic [SYNC_N-1:0] SYNC_IDLE = 10'h3F8;

    typedef enum logic {FCSR_SIZE_4M, FCSR_SIZE_8M} fcsr_size_t;

    typedef struct packed {
        logic pageEnable;
        logic [1:0] pageSelectBits;
    } fcsr_page_t;

    typedef struct packed {
        logic dataOut;
        logic dataOe;
    } fcsr_pin_t;
endpackage : fcsr_pkg

//--- rtl/fcsr_readout.sv
`timescale 1ns/1ps
// Functional notes
// - Output enable low loads address counter with active base (page start when paging), clears bit counter, data floats.
// - Chip select high freezes counters, floats data, signals standby.
// - Output enable low resets and floats regardless of chip select.
// - Chip select low with enable high: clock advances counter, drives data.
// - After last bit and cascade low, data output floats.
// - Address counter cleared automatically at power-up.
// - Data pin three-state in read-out, open-collector bidirectional when programming.
// - Serial clock is input when programming, output during read-out.
// - Page mode splits space into four pages, page select picks one.
// - 4-Mbit page n spans n*10000h to plus 0FFFFh.
// - 8-Mbit page n spans n*20000h to plus 1FFFFh.
// - Paging off ignores page select, reads whole device.
// - In programming mode page inputs have no effect.
// - Chip select has no effect in programming mode.
// - Cascade output low when address counter reaches active maximum.
// - Cascade stays low, then follows chip select until enable falls.
// - Device select acts as chip select for programming.
// - Ready driven low during power-up reset, then released.
// - Programming enable low selects programming mode.
// - Standby floats output regardless of output enable.
// - Downstream device enables output when its chip select goes low.
module fcsr_readout
    import fcsr_pkg::*;
#(
    parameter fcsr_size_t SIZE = FCSR_SIZE_8M,
    parameter int unsigned READY_CYCLES = READY_DELAY,
    parameter logic [ADDR_W-1:0] PAGE_SPAN = (SIZE == FCSR_SIZE_8M) ? PAGE_SPAN_8M : PAGE_SPAN_4M
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    input wire logic programModeEnableN,
    input wire logic chipSelectN,
    input wire logic resetOutputEnable,
    input wire logic programDeviceSelect,
    input wire fcsr_page_t pageConfig,
    input wire logic serialBitClockIn,
    input wire logic dataIn,
    input wire logic progDataLow,
    input wire logic [WORD_W-1:0] memWord,
    output logic [ADDR_W-1:0] memAddr,
    output fcsr_pin_t dataPin,
    output logic serialBitClockOut,
    output logic serialBitClockOe,
    output logic chainHandoverN,
    output logic readyOut,
    output logic readyOe,
    output logic standby,
    output logic inSystemProgramming,
    output logic programSelected,
    output logic progDataIn,
    output logic progClockIn
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_N-1:0] pinRaw;
    logic [SYNC_N-1:0] syncA_q, syncA_d;
    logic [SYNC_N-1:0] syncB_q, syncB_d;
    assign pinRaw = {programModeEnableN, chipSelectN, resetOutputEnable, programDeviceSelect,
                     serialBitClockIn, dataIn, progDataLow, pageConfig};
    // idle reset levels keep the block out of a false clear after reset
    for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
        always_comb begin
            syncA_d[g] = clockEnable ? pinRaw[g] : syncA_q[g];
            syncB_d[g] = clockEnable ? syncA_q[g] : syncB_q[g];
        end
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                syncA_q[g] <= SYNC_IDLE[g];
                syncB_q[g] <= SYNC_IDLE[g];
            end else begin
                syncA_q[g] <= syncA_d[g];
                syncB_q[g] <= syncB_d[g];
            end
        end
    end
    logic progN, csN, oe, pageEnB;
    logic [1:0] pageSelB;
    assign progN = syncB_q[9];
    assign csN = syncB_q[8];
    assign oe = syncB_q[7];
    assign pageEnB = syncB_q[2];
    assign pageSelB = syncB_q[1:0];
    assign inSystemProgramming = ~progN;
    assign programSelected = ~progN & syncB_q[6];
    assign progClockIn = syncB_q[5];
    assign progDataIn = syncB_q[4];

    // ------------------------------------------------------------
    // active range
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] baseAddr, topAddr, pageTop, devTop;
    logic pagingOn;
    always_comb begin
        // device is four pages, so its top is four spans less one
        pageTop = PAGE_SPAN - 19'h00001;
        devTop = ADDR_W'({PAGE_SPAN, 2'b00} - 21'h000001);
        pagingOn = pageEnB & progN;
        if (pagingOn) begin
            baseAddr = ADDR_W'(PAGE_SPAN * pageSelB);
            topAddr = baseAddr + pageTop;
        end else begin
            baseAddr = ADDR_RESET;
            topAddr = devTop;
        end
    end

    // ------------------------------------------------------------
    // read-out counters and cascade
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FCSR_READ, FCSR_DONE_LOW, FCSR_DONE_FOLLOW} fcsr_state_t;
    fcsr_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [BIT_W-1:0] bit_q, bit_d;
    logic [WORD_W-1:0] shift_q, shift_d;
    logic primed_q, primed_d;
    logic tick_q, tick_d;
    logic refill_q, refill_d;
    logic running, lastBit;
    // counting gated by select only in read-out
    assign running = progN & ~csN & oe;
    assign lastBit = (addr_q == topAddr) && (bit_q == BIT_W'(WORD_W - 1));
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        bit_d = bit_q;
        shift_d = shift_q;
        primed_d = primed_q;
        tick_d = ~tick_q;
        refill_d = refill_q;
        if (!progN) begin
            tick_d = 1'b0;
        end else if (!oe) begin
            addr_d = baseAddr;
            bit_d = BIT_RESET;
            primed_d = 1'b0;
            refill_d = 1'b0;
            state_d = FCSR_READ;
        end else if (running && state_q == FCSR_READ) begin
            // one bit per serial clock, ascending
            if (!primed_q || refill_q) begin
                // word fetch in the low phase, so no serial clock is lost
                shift_d = memWord;
                primed_d = 1'b1;
                refill_d = 1'b0;
            end else if (tick_q) begin
                if (lastBit) begin
                    state_d = FCSR_DONE_LOW;
                end else if (bit_q == BIT_W'(WORD_W - 1)) begin
                    bit_d = BIT_RESET;
                    addr_d = addr_q + 19'h00001;
                    refill_d = 1'b1;
                end else begin
                    bit_d = bit_q + 4'h1;
                    shift_d = {shift_q[WORD_W-2:0], 1'b0};
                end
            end
        end else if (state_q == FCSR_DONE_LOW && csN) begin
            state_d = FCSR_DONE_FOLLOW;
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= FCSR_READ;
            addr_q <= ADDR_RESET;
            bit_q <= BIT_RESET;
            shift_q <= '0;
            primed_q <= 1'b0;
            tick_q <= 1'b0;
            refill_q <= 1'b0;
        end else if (clockEnable) begin
            state_q <= state_d;
            addr_q <= addr_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            primed_q <= primed_d;
            tick_q <= tick_d;
            refill_q <= refill_d;
        end
    end

    // ------------------------------------------------------------
    // power-up ready counter
    // ------------------------------------------------------------
    logic [7:0] rdyCnt_q, rdyCnt_d;
    always_comb begin
        rdyCnt_d = rdyCnt_q;
        // saturates, so ready never drops again without a reset
        if (rdyCnt_q != 8'(READY_CYCLES)) begin
            rdyCnt_d = rdyCnt_q + 8'h01;
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdyCnt_q <= 8'h00;
        end else if (clockEnable) begin
            rdyCnt_q <= rdyCnt_d;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic done;
    assign done = (state_q != FCSR_READ);
    assign memAddr = addr_q;
    assign standby = progN & csN;
    assign dataPin.dataOut = progN ? shift_q[WORD_W-1] : 1'b0;
    assign dataPin.dataOe = progN ? (running & primed_q & ~done) : syncB_q[3];
    assign serialBitClockOut = tick_q;
    assign serialBitClockOe = progN;
    always_comb begin
        case (state_q)
            FCSR_DONE_LOW: chainHandoverN = 1'b0;
            FCSR_DONE_FOLLOW: chainHandoverN = csN;
            default: chainHandoverN = 1'b1;
        endcase
        if (!progN) begin
            chainHandoverN = 1'b1;
        end
    end
    assign readyOut = 1'b0;
    assign readyOe = (rdyCnt_q != 8'(READY_CYCLES));
endmodule : fcsr_readout

//--- tb/fcsr_mem_model.sv
`timescale 1ns/1ps
module fcsr_mem_model
    import fcsr_pkg::*;
(
    input wire logic [ADDR_W-1:0] memAddr,
    output logic [WORD_W-1:0] memWord
);
    // address-derived word, so a stuck counter shows
    assign memWord = {memAddr[7:0], ~memAddr[7:0]};
endmodule : fcsr_mem_model

//--- tb/fcsr_readout_monitor.sv
`timescale 1ns/1ps
module fcsr_readout_monitor
    import fcsr_pkg::*;
#(
    parameter int unsigned READY_CYCLES = READY_DELAY
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic programModeEnableN,
    input wire logic chipSelectN,
    input wire logic resetOutputEnable,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire fcsr_pin_t dataPin,
    input wire logic serialBitClockOe,
    input wire logic chainHandoverN,
    input wire logic readyOut,
    input wire logic readyOe,
    input wire logic standby
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // windows of 6 cover the input synchronisers
    logic [7:0] upCnt_q;
    logic [7:0] upCnt_d;
    always_comb upCnt_d = (upCnt_q == 8'hFF) ? upCnt_q : upCnt_q + 8'h01;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) upCnt_q <= 8'h00;
        else upCnt_q <= upCnt_d;
    end
    property p_oe_low; (programModeEnableN && !resetOutputEnable)[*6] |-> !dataPin.dataOe; endproperty
    property p_oe_chain; (programModeEnableN && !resetOutputEnable)[*6] |-> chainHandoverN; endproperty
    property p_standby; (programModeEnableN && chipSelectN)[*6] |-> standby && !dataPin.dataOe; endproperty
    property p_freeze;
        (programModeEnableN && chipSelectN && resetOutputEnable)[*6] |=> $stable(memAddr);
    endproperty
    property p_drive;
        (programModeEnableN && !chipSelectN && resetOutputEnable && chainHandoverN)[*6]
            |-> dataPin.dataOe;
    endproperty
    property p_done; (programModeEnableN && !chainHandoverN)[*6] |-> !dataPin.dataOe; endproperty
    property p_prog_clk; (!programModeEnableN)[*6] |-> !serialBitClockOe && !standby; endproperty
    property p_read_clk; programModeEnableN[*6] |-> serialBitClockOe; endproperty
    property p_ready; readyOe |-> !readyOut; endproperty
    property p_ready_end; (upCnt_q == READY_CYCLES + 4) |-> !readyOe; endproperty
    property p_power_up; (upCnt_q == 8'h01) |-> memAddr == ADDR_RESET; endproperty
    a_oe_low: assert property (p_oe_low)
        else $error("data driven with output enable low");
    a_oe_chain: assert property (p_oe_chain)
        else $error("cascade low with output enable low");
    a_standby: assert property (p_standby)
        else $error("no standby with chip select high");
    a_freeze: assert property (p_freeze)
        else $error("address moved with chip select high");
    a_drive: assert property (p_drive)
        else $error("data not driven while selected");
    a_done: assert property (p_done)
        else $error("data driven after handover");
    a_prog_clk: assert property (p_prog_clk)
        else $error("clock driven or standby in programming");
    a_read_clk: assert property (p_read_clk)
        else $error("clock not driven in read-out");
    a_ready: assert property (p_ready)
        else $error("ready pin driven high");
    a_ready_end: assert property (p_ready_end)
        else $error("ready not released");
    a_power_up: assert property (p_power_up)
        else $error("address not cleared at power-up");
    cover property (programModeEnableN && !chipSelectN && dataPin.dataOe);
    cover property (standby);
    cover property (!serialBitClockOe);
    cover property (programModeEnableN && !chainHandoverN);
endmodule : fcsr_readout_monitor
bind fcsr_readout fcsr_readout_monitor #(.READY_CYCLES(READY_CYCLES)) fcsr_readout_monitor_i (.*);

//--- tb/test_fpga_config_serial_readout.sv
`timescale 1ns/1ps
module test_fpga_config_serial_readout;
    import fcsr_pkg::*;
    logic clock, reset, clockEnable, programModeEnableN, chipSelectN, resetOutputEnable;
    logic programDeviceSelect, serialBitClockIn, dataIn, progDataLow;
    logic serialBitClockOut, serialBitClockOe, chainHandoverN, readyOut, readyOe, standby;
    logic inSystemProgramming, programSelected, progDataIn, progClockIn;
    fcsr_page_t pageConfig, cfg;
    fcsr_pin_t dataPin;
    logic [WORD_W-1:0] memWord;
    logic [ADDR_W-1:0] memAddr, a0;
    int n_mismatch, n_tests, cyc;
    // small pages so a whole page and device read fit the run
    localparam logic [ADDR_W-1:0] TB_SPAN = 19'h00004;
    logic clkPrev;
    logic [ADDR_W-1:0] expAddr;
    logic [3:0] expIdx;
    logic [WORD_W-1:0] expWord;
    fcsr_readout #(.READY_CYCLES(2), .PAGE_SPAN(TB_SPAN)) fcsr_readout_i (.*);
    fcsr_mem_model fcsr_mem_model_i (.*);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step
    task automatic check(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [ADDR_W-1:0] base(input fcsr_page_t p);
        return p.pageEnable ? ADDR_W'(TB_SPAN * p.pageSelectBits) : ADDR_RESET;
    endfunction : base
    function automatic logic [WORD_W-1:0] word(input logic [ADDR_W-1:0] a);
        return {a[7:0], ~a[7:0]};
    endfunction : word
    // receiver side: one bit taken at each rising serial clock, msb first
    always @(posedge clock) begin
        clkPrev <= serialBitClockOut;
        if (!resetOutputEnable) begin
            expAddr <= base(pageConfig);
            expIdx <= 4'h0;
        end else if (serialBitClockOe && dataPin.dataOe && serialBitClockOut && !clkPrev) begin
            expWord = word(expAddr);
            check(ADDR_W'(dataPin.dataOut), ADDR_W'(expWord[4'hF - expIdx]));
            expIdx <= expIdx + 4'h1;
            if (expIdx == 4'hF) expAddr <= expAddr + 19'h00001;
        end
    end
    task automatic final_report;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    // run is about 30000 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        {reset, clockEnable, programModeEnableN, chipSelectN, resetOutputEnable} = 5'h1F;
        {programDeviceSelect, serialBitClockIn, dataIn, progDataLow} = 4'h0;
        pageConfig = 3'h0;
        void'($urandom(32'h21d7));
        step(6);
        reset <= 1'b0;
        step(3);
        check(memAddr, ADDR_RESET);
        for (int i = 0; i < 40; i++) begin
            cfg = (i < 8) ? fcsr_page_t'(3'(i)) : fcsr_page_t'(3'($urandom));
            pageConfig <= cfg;
            resetOutputEnable <= 1'b0;
            chipSelectN <= 1'($urandom);
            dataIn <= 1'($urandom);
            step(8);
            check(memAddr, base(cfg));
            check(ADDR_W'({dataPin.dataOe, chainHandoverN, readyOe}), 19'h00002);
            chipSelectN <= 1'b0;
            resetOutputEnable <= 1'b1;
            step(50 + $urandom % 50);
            check(ADDR_W'({dataPin.dataOe, standby}), 19'h00002);
            check(ADDR_W'((memAddr - base(cfg)) inside {[1:7]}), 19'h00001);
            clockEnable <= 1'b0;
            step(2);
            a0 = memAddr;
            step(8);
            check(memAddr, a0);
            clockEnable <= 1'b1;
            chipSelectN <= 1'b1;
            step(6);
            a0 = memAddr;
            step(20);
            check(memAddr, a0);
            check(ADDR_W'({dataPin.dataOe, standby}), 19'h00001);
            chipSelectN <= 1'b0;
            step(600);
            check(ADDR_W'({chainHandoverN, dataPin.dataOe}), 19'h00000);
            chipSelectN <= 1'b1;
            step(6);
            check(ADDR_W'(chainHandoverN), 19'h00001);
            chipSelectN <= 1'b0;
            step(6);
            check(ADDR_W'({chainHandoverN, dataPin.dataOe}), 19'h00000);
            programModeEnableN <= 1'b0;
            {chipSelectN, progDataLow, programDeviceSelect, serialBitClockIn} <= 4'($urandom);
            pageConfig <= 3'($urandom);
            step(8);
            check(ADDR_W'({dataPin, standby, serialBitClockOe, programSelected}),
                ADDR_W'({1'b0, progDataLow, 2'h0, programDeviceSelect}));
            programModeEnableN <= 1'b1;
            step(6);
        end
        final_report();
    end
endmodule : test_fpga_config_serial_readout
